// ===== hdl/qbs_pkg.sv
// Shared constants and types for the quad-rate burst SRAM port and its controller
package qbs_pkg;

  // Word and array geometry (x18 configuration, small flop array)
  localparam int DATA_W  = 18;
  localparam int LANE_W  = 9;
  localparam int SEL_W   = DATA_W / LANE_W;
  localparam int ADDR_W  = 4;
  localparam int DEPTH   = 1 << ADDR_W;
  localparam int BURST   = 4;

  // Link clock made by the controller from clk_in
  localparam int CLK_NS     = 10;
  localparam int K_HALF_NS  = 40;
  localparam int K_HALF_CYC = (K_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int K_CNT_W    = 4;

  // Read latency in link edges (two edges per link clock period)
  localparam logic [3:0] LAT_PLL_EDGES = 4'h5;
  localparam logic [3:0] LAT_BYP_EDGES = 4'h2;

  // Edge phases within the two-period address schedule
  localparam logic [1:0] PH_READ  = 2'h0;
  localparam logic [1:0] PH_WRITE = 2'h2;
  localparam logic [1:0] PH_RESET = 2'h3;

  // Reset levels of the link clock pair and its samplers
  localparam logic       K_RESET      = 1'h0;
  localparam logic       K_N_RESET    = 1'h1;
  localparam logic [2:0] K_SYN_RESET  = 3'h0;
  localparam logic [2:0] KN_SYN_RESET = 3'h7;

  typedef logic [DATA_W-1:0]       qbs_word_type;
  typedef logic [ADDR_W-1:0]       qbs_addr_type;
  typedef logic [SEL_W-1:0]        qbs_sel_type;
  typedef qbs_word_type [BURST-1:0] qbs_burst_type;
  typedef qbs_sel_type [BURST-1:0]  qbs_burst_sel_type;

endpackage

// ===== hdl/qbs_link_if.sv
// Pin-level link between the burst SRAM port and its controller
`timescale 1ns/1ps
`default_nettype none
interface qbs_link_if;
  import qbs_pkg::*;

  logic         k_clk;
  logic         k_clk_n;
  qbs_addr_type addr;
  logic         read_select_n;
  logic         write_select_n;
  qbs_word_type wdata;
  qbs_sel_type  byte_write_select_n;
  logic         pll_bypass_select;
  qbs_word_type rdata;
  logic         read_valid_flag;
  logic         echo_clock_out;
  logic         echo_clock_n_out;

  modport host (
    output k_clk, k_clk_n, addr, read_select_n, write_select_n, wdata,
           byte_write_select_n, pll_bypass_select,
    input  rdata, read_valid_flag, echo_clock_out, echo_clock_n_out
  );

  modport dev (
    input  k_clk, k_clk_n, addr, read_select_n, write_select_n, wdata,
           byte_write_select_n, pll_bypass_select,
    output rdata, read_valid_flag, echo_clock_out, echo_clock_n_out
  );
endinterface
`default_nettype wire

// ===== hdl/qbs_ctrl.sv
// Memory controller end: makes the link clock, issues bursts, captures read data
`timescale 1ns/1ps
`default_nettype none
module qbs_ctrl
  import qbs_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  qbs_link_if.host               link,
  input  wire logic              pll_on_in,
  input  wire logic              rd_req_in,
  input  wire qbs_addr_type      rd_addr_in,
  output logic                   rd_ack_out,
  output qbs_word_type           rd_data_out,
  output logic                   rd_valid_out,
  input  wire logic              wr_req_in,
  input  wire qbs_addr_type      wr_addr_in,
  input  wire qbs_burst_type     wr_data_in,
  input  wire qbs_burst_sel_type wr_lane_sel_n_in,
  output logic                   wr_ack_out
);

  typedef struct packed {
    logic [K_CNT_W-1:0] kcnt;
    logic               k;
    logic               k_n;
    logic [1:0]         phase;
    qbs_addr_type       addr;
    logic               rsel_n;
    logic               wsel_n;
    qbs_word_type       d;
    qbs_sel_type        bw_n;
    logic               pll;
    qbs_burst_type      wbuf;
    qbs_burst_sel_type  wbw_n;
    logic [2:0]         echo_s;
    logic [2:0]         echo_n_s;
    qbs_word_type       q_s1;
    qbs_word_type       q_s2;
    logic               qv_s1;
    logic               qv_s2;
    qbs_word_type       rd_data;
    logic               rd_valid;
    logic               rd_ack;
    logic               wr_ack;
  } qbs_ctrl_state_type;

  qbs_ctrl_state_type st;
  qbs_ctrl_state_type next_st;
  logic [1:0]         ph;
  logic [1:0]         np;
  logic               e_rise;

  always_comb begin
    next_st          = st;
    ph               = st.phase;
    np               = st.phase;
    next_st.rd_ack   = 1'b0;
    next_st.wr_ack   = 1'b0;
    next_st.rd_valid = 1'b0;
    next_st.pll      = pll_on_in;
    if (st.kcnt == K_CNT_W'(K_HALF_CYC - 1)) begin
      next_st.kcnt  = '0;
      next_st.k     = ~st.k;
      next_st.k_n   = st.k;
      ph            = st.phase + 2'h1;
      np            = ph + 2'h1;
      next_st.phase = ph;
      next_st.d    = st.wbuf[np + 2'h1];
      next_st.bw_n = st.wbw_n[np + 2'h1];
      if (np == PH_READ) begin
        next_st.rsel_n = ~rd_req_in;
        if (rd_req_in) begin
          next_st.addr   = rd_addr_in;
          next_st.rd_ack = 1'b1;
        end
      end
      if (np == PH_WRITE) begin
        next_st.wsel_n = ~wr_req_in;
        if (wr_req_in) begin
          next_st.addr   = wr_addr_in;
          next_st.wbuf   = wr_data_in;
          next_st.wbw_n  = wr_lane_sel_n_in;
          next_st.wr_ack = 1'b1;
        end
      end
    end else begin
      next_st.kcnt = st.kcnt + K_CNT_W'(1);
    end
    next_st.echo_s   = {st.echo_s[1:0], link.echo_clock_out};
    next_st.echo_n_s = {st.echo_n_s[1:0], link.echo_clock_n_out};
    next_st.q_s1     = link.rdata;
    next_st.q_s2     = st.q_s1;
    next_st.qv_s1    = link.read_valid_flag;
    next_st.qv_s2    = st.qv_s1;
    e_rise = (st.echo_s[1] & ~st.echo_s[2]) | (st.echo_n_s[1] & ~st.echo_n_s[2]);
    if (e_rise && st.qv_s2) begin
      next_st.rd_data  = st.q_s2;
      next_st.rd_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st          <= '0;
      st.k        <= K_RESET;
      st.k_n      <= K_N_RESET;
      st.phase    <= PH_RESET;
      st.rsel_n   <= 1'h1;
      st.wsel_n   <= 1'h1;
      st.wbw_n    <= '1;
      st.echo_n_s <= KN_SYN_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign link.k_clk               = st.k;
  assign link.k_clk_n             = st.k_n;
  assign link.addr                = st.addr;
  assign link.read_select_n       = st.rsel_n;
  assign link.write_select_n      = st.wsel_n;
  assign link.wdata               = st.d;
  assign link.byte_write_select_n = st.bw_n;
  assign link.pll_bypass_select   = st.pll;
  assign rd_ack_out               = st.rd_ack;
  assign rd_data_out              = st.rd_data;
  assign rd_valid_out             = st.rd_valid;
  assign wr_ack_out               = st.wr_ack;

endmodule
`default_nettype wire

// ===== hdl/qbs_sram.sv
// Burst SRAM end: separate DDR read and write ports over a shared address bus
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Separate read output and write input pins
// - Read, write addresses on alternate clock rises
// - Each address moves four sequential words
// - One word on each true/complement rise
// - Only rising edges of both clocks count
// - PLL on: read data 2.5 cycles later
// - PLL bypassed: read data one cycle later
// - Free-running echo clocks aligned with data
// - Valid flag high only while data driven
// - Independent read and write port selects
// - Read and write ports never stall each other
// - Inputs captured in registers on clock edges
// - Read data launched from output registers
// - Writes completed internally, self-timed
// - Reads return most recently written data
// - Output placement aligned to input clock
module qbs_sram
  import qbs_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  qbs_link_if.dev   link
);

  typedef struct packed {
    logic [2:0]                  k_s;
    logic [2:0]                  k_n_s;
    qbs_addr_type                a_s1;
    qbs_addr_type                a_s2;
    qbs_addr_type                a_s3;
    logic                        rsel_n_s1;
    logic                        rsel_n_s2;
    logic                        rsel_n_s3;
    logic                        wsel_n_s1;
    logic                        wsel_n_s2;
    logic                        wsel_n_s3;
    qbs_word_type                d_s1;
    qbs_word_type                d_s2;
    qbs_word_type                d_s3;
    qbs_sel_type                 bw_n_s1;
    qbs_sel_type                 bw_n_s2;
    qbs_sel_type                 bw_n_s3;
    logic                        pll_s1;
    logic                        pll_s2;
    logic [1:0]                  phase;
    qbs_burst_type [DEPTH-1:0]   mem;
    logic                        wact;
    logic [1:0]                  widx;
    qbs_addr_type                waddr;
    logic                        bank;
    logic [1:0]                  bact;
    logic [1:0]                  bfwd;
    logic [1:0][3:0]             bcnt;
    qbs_burst_type [1:0]         rbuf;
    qbs_word_type                q;
    logic                        qv;
    logic                        echo;
    logic                        echo_n;
  } qbs_sram_state_type;

  qbs_sram_state_type st;
  qbs_sram_state_type next_st;
  logic               k_rise;
  logic               k_n_rise;
  logic               edge_seen;
  logic [1:0]         ph;
  logic [3:0]         lat;
  logic [3:0]         c;
  logic               nb;
  qbs_word_type       merged;

  // Byte lanes with an active-low select take the new data
  function automatic qbs_word_type qbs_merge(
    input qbs_word_type old_w,
    input qbs_word_type new_w,
    input qbs_sel_type  bw_n
  );
    qbs_word_type r;
    r = old_w;
    for (int i = 0; i < SEL_W; i++) begin
      if (!bw_n[i]) begin
        r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction

  always_comb begin
    next_st = st;
    ph      = st.phase;
    c       = '0;
    nb      = st.bank;
    merged  = '0;

    next_st.k_s       = {st.k_s[1:0], link.k_clk};
    next_st.k_n_s     = {st.k_n_s[1:0], link.k_clk_n};
    next_st.a_s1      = link.addr;
    next_st.a_s2      = st.a_s1;
    next_st.rsel_n_s1 = link.read_select_n;
    next_st.rsel_n_s2 = st.rsel_n_s1;
    next_st.wsel_n_s1 = link.write_select_n;
    next_st.wsel_n_s2 = st.wsel_n_s1;
    next_st.d_s1      = link.wdata;
    next_st.d_s2      = st.d_s1;
    next_st.bw_n_s1   = link.byte_write_select_n;
    next_st.bw_n_s2   = st.bw_n_s1;
    // Third stage lines up with k_s[2]: the level held before the edge
    next_st.a_s3      = st.a_s2;
    next_st.rsel_n_s3 = st.rsel_n_s2;
    next_st.wsel_n_s3 = st.wsel_n_s2;
    next_st.d_s3      = st.d_s2;
    next_st.bw_n_s3   = st.bw_n_s2;
    next_st.pll_s1    = link.pll_bypass_select;
    next_st.pll_s2    = st.pll_s1;

    k_rise    = st.k_s[1] & ~st.k_s[2];
    k_n_rise  = st.k_n_s[1] & ~st.k_n_s[2];
    edge_seen = k_rise | k_n_rise;

    next_st.echo   = st.k_s[1];
    next_st.echo_n = st.k_n_s[1];

    lat = st.pll_s2 ? LAT_PLL_EDGES : LAT_BYP_EDGES;
    if (!st.pll_s2) begin
      lat = LAT_BYP_EDGES;
    end

    if (edge_seen) begin
      ph            = st.phase + 2'h1;
      next_st.phase = ph;

      if (st.wact) begin
        merged = qbs_merge(st.mem[st.waddr][st.widx], st.d_s3, st.bw_n_s3);
        next_st.mem[st.waddr][st.widx] = merged;
        for (int b = 0; b < 2; b++) begin
          if (st.bact[b] && st.bfwd[b]) begin
            next_st.rbuf[b][st.widx] = merged;
          end
        end
        next_st.widx = st.widx + 2'h1;
        if (st.widx == 2'h3) begin
          next_st.wact = 1'b0;
          next_st.bfwd = '0;
        end
      end

      next_st.qv = 1'b0;
      for (int b = 0; b < 2; b++) begin
        if (st.bact[b]) begin
          c                = st.bcnt[b] + 4'h1;
          next_st.bcnt[b]  = c;
          if (c >= lat && c < lat + 4'h4) begin
            next_st.q  = st.rbuf[b][2'(c - lat)];
            next_st.qv = 1'b1;
          end
          if (c == lat + 4'h3) begin
            next_st.bact[b] = 1'b0;
          end
        end
      end

      if (ph == PH_READ && k_rise) begin
        if (!st.rsel_n_s3) begin
          nb               = ~st.bank;
          next_st.bank     = nb;
          next_st.bact[nb] = 1'b1;
          next_st.bcnt[nb] = '0;
          next_st.rbuf[nb] = next_st.mem[st.a_s3];
          next_st.bfwd[nb] = next_st.wact && (st.waddr == st.a_s3);
        end
      end

      if (ph == PH_WRITE && k_rise) begin
        if (!st.wsel_n_s3) begin
          next_st.wact  = 1'b1;
          next_st.widx  = '0;
          next_st.waddr = st.a_s3;
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st        <= '0;
      st.k_s    <= K_SYN_RESET;
      st.k_n_s  <= KN_SYN_RESET;
      st.phase  <= PH_RESET;
      st.echo_n <= K_N_RESET;
      st.rsel_n_s1 <= 1'h1;
      st.rsel_n_s2 <= 1'h1;
      st.rsel_n_s3 <= 1'h1;
      st.wsel_n_s1 <= 1'h1;
      st.wsel_n_s2 <= 1'h1;
      st.wsel_n_s3 <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  assign link.rdata            = st.q;
  assign link.read_valid_flag  = st.qv;
  assign link.echo_clock_out   = st.echo;
  assign link.echo_clock_n_out = st.echo_n;

endmodule
`default_nettype wire

// ===== tb/qbs_monitor.sv
// Link-level checks between the burst SRAM port and its controller
`timescale 1ns/1ps
`default_nettype none
module qbs_monitor
  import qbs_pkg::*;
(
  input wire logic         clk_in,
  input wire logic         rst_in,
  input wire logic         k_clk,
  input wire logic         k_clk_n,
  input wire qbs_addr_type addr,
  input wire logic         read_select_n,
  input wire logic         write_select_n,
  input wire qbs_word_type wdata,
  input wire logic         pll_bypass_select,
  input wire logic         read_valid_flag,
  input wire logic         echo_clock_out
);
  logic       k_q;
  logic       odd;
  logic [7:0] since_rd;
  logic       rd_edge;

  // Read slot is every other rise of k_clk, the first one after reset
  assign rd_edge = k_clk && !k_q && !odd && !read_select_n;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      k_q      <= 1'h0;
      odd      <= 1'h0;
      since_rd <= 8'hff;
    end else begin
      k_q <= k_clk;
      if (k_clk && !k_q) begin
        odd <= !odd;
      end
      if (rd_edge) begin
        since_rd <= 8'h00;
      end else if (since_rd != 8'hff) begin
        since_rd <= since_rd + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_rd_edge;
    rd_edge;
  endsequence
  sequence s_k_high;
    k_clk [*4] ##1 !k_clk;
  endsequence

  property p_k_compl;
    k_clk_n == !k_clk;
  endproperty
  property p_k_half;
    $rose(k_clk) |-> s_k_high;
  endproperty
  property p_addr_setup;
    $rose(k_clk) |-> $stable(addr) && $stable(read_select_n) && $stable(write_select_n);
  endproperty
  property p_wdata_setup;
    ($rose(k_clk) || $rose(k_clk_n)) |-> $past(wdata) == $past(wdata, 4);
  endproperty
  property p_echo_follow;
    $rose(k_clk) |-> ##[1:6] $rose(echo_clock_out);
  endproperty
  property p_valid_len;
    $rose(read_valid_flag) |-> read_valid_flag [*8];
  endproperty
  property p_valid_cause;
    $rose(read_valid_flag) |-> since_rd < 8'h28;
  endproperty
  property p_lat_pll;
    s_rd_edge ##0 pll_bypass_select |-> ##[21:27] read_valid_flag;
  endproperty
  property p_lat_byp;
    s_rd_edge ##0 !pll_bypass_select |-> ##[9:15] read_valid_flag;
  endproperty

  a_k_compl: assert property (p_k_compl) else $error("link clock pair not complementary");
  a_k_half: assert property (p_k_half) else $error("link clock high time wrong");
  a_addr_setup: assert property (p_addr_setup) else $error("address moved on its edge");
  a_wdata_setup: assert property (p_wdata_setup) else $error("write word moved on its edge");
  a_echo_follow: assert property (p_echo_follow) else $error("echo clock not following");
  a_valid_len: assert property (p_valid_len) else $error("valid flag too short");
  a_valid_cause: assert property (p_valid_cause) else $error("valid flag without read");
  a_lat_pll: assert property (p_lat_pll) else $error("read data late with pll on");
  a_lat_byp: assert property (p_lat_byp) else $error("read data late with pll off");
endmodule
`default_nettype wire

// ===== tb/quad_rate_burst_sram_port_bench.sv
// Testbench joining the controller and SRAM ends across the link
`timescale 1ns/1ps
`default_nettype none
module quad_rate_burst_sram_port_bench
  import qbs_pkg::*;
;
  logic              clk_in      = 1'h0;
  logic              rst_in      = 1'h1;
  logic              pll_on_in   = 1'h1;
  logic              rd_req_in   = 1'h0;
  qbs_addr_type      rd_addr_in  = '0;
  logic              rd_ack_out;
  qbs_word_type      rd_data_out;
  logic              rd_valid_out;
  logic              wr_req_in   = 1'h0;
  qbs_addr_type      wr_addr_in  = '0;
  qbs_burst_type     wr_data_in  = '0;
  qbs_burst_sel_type wr_lane_sel_n_in = '1;
  logic              wr_ack_out;
  qbs_burst_type     model [DEPTH] = '{default: '0};
  int                err_total   = 0;
  int                n_tests     = 0;

  always #5 clk_in = !clk_in;

  qbs_link_if link ();
  qbs_ctrl i_qbs_ctrl (.clk_in(clk_in), .rst_in(rst_in), .link(link), .pll_on_in(pll_on_in),
    .rd_req_in(rd_req_in), .rd_addr_in(rd_addr_in), .rd_ack_out(rd_ack_out), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .wr_req_in(wr_req_in), .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in),
    .wr_lane_sel_n_in(wr_lane_sel_n_in), .wr_ack_out(wr_ack_out));
  qbs_sram i_qbs_sram (.clk_in(clk_in), .rst_in(rst_in), .link(link));
  qbs_monitor i_qbs_monitor (.clk_in(clk_in), .rst_in(rst_in), .k_clk(link.k_clk), .k_clk_n(link.k_clk_n),
    .addr(link.addr), .read_select_n(link.read_select_n), .write_select_n(link.write_select_n),
    .wdata(link.wdata), .pll_bypass_select(link.pll_bypass_select),
    .read_valid_flag(link.read_valid_flag), .echo_clock_out(link.echo_clock_out));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic fail(input string s);
    err_total++;
    $display("mismatch at %0t: %s", $time, s);
  endtask

  task automatic chk_word(input qbs_word_type got, input qbs_word_type exp);
    n_tests++;
    if (got !== exp) fail($sformatf("read word %h expected %h", got, exp));
  endtask

  task automatic chk_lat(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) fail($sformatf("read latency %0d cycles", got));
  endtask

  task automatic wr(input qbs_addr_type a, input qbs_burst_type d, input qbs_burst_sel_type m);
    int i;
    @(negedge clk_in);
    wr_req_in   = 1'h1;
    wr_addr_in  = a;
    wr_data_in  = d;
    wr_lane_sel_n_in = m;
    i = 0;
    do begin @(negedge clk_in); i++; end while (wr_ack_out !== 1'h1 && i < 40);
    wr_req_in = 1'h0;
    if (i >= 40) fail("write not taken");
    // Lanes with a low select take the new word, others keep the old one
    for (int w = 0; w < BURST; w++)
      for (int l = 0; l < SEL_W; l++)
        if (m[w][l] === 1'h0) model[a][w][l*LANE_W +: LANE_W] = d[w][l*LANE_W +: LANE_W];
  endtask

  task automatic rd(input qbs_addr_type a);
    int i;
    int lo;
    @(negedge clk_in);
    rd_req_in  = 1'h1;
    rd_addr_in = a;
    lo = (1 + int'(pll_on_in ? LAT_PLL_EDGES : LAT_BYP_EDGES)) * K_HALF_CYC;
    i = 0;
    do begin @(negedge clk_in); i++; end while (rd_ack_out !== 1'h1 && i < 40);
    rd_req_in = 1'h0;
    if (i >= 40) fail("read not taken");
    i = 0;
    do begin @(negedge clk_in); i++; end while (rd_valid_out !== 1'h1 && i < 60);
    chk_lat(i, lo + 1, lo + 6);
    for (int w = 0; w < BURST; w++) begin
      i = 0;
      if (w > 0)
        do begin @(negedge clk_in); i++; end while (rd_valid_out !== 1'h1 && i < 8);
      if (i >= 8) fail("read word missing");
      chk_word(rd_data_out, model[a][w]);
    end
  endtask

  initial begin
    repeat (6000) @(posedge clk_in);
    fail("watchdog expired");
    end_sim();
  end

  initial begin
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'h0;
    wr(4'h3, 72'h0123456789abcdef01, '0);
    rd(4'h3);
    wr(4'h3, 72'hfedcba9876543210fe, 8'h96);
    wr(4'h9, 72'h3c3c3c3c3c3c3c3c3c, '0);
    rd(4'h3);
    rd(4'h9);
    fork
      wr(4'hc, 72'ha5a5a5a5a5a5a5a5a5, '0);
      rd(4'h9);
    join
    rd(4'h5);
    rd(4'hc);
    pll_on_in = 1'h0;
    repeat (16) @(negedge clk_in);
    rd(4'h3);
    rd(4'hc);
    end_sim();
  end
endmodule
`default_nettype wire
